// file: src/reset_and_stop_recovery.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_params.svh"
// Behaviour
// - 3-clk pulse may reset, 4-clk always
// - stay in reset while pin held low, if this reset does not drive the pin itself
// - leave reset first edge after release
// - external reset sets external_reset_flag
// - pin drives open-drain low during reset, except external reset
// - internal events drive pin until delay ends
// - debug request starts power-on style reset
// - debug reset spares the debug unit
// - debug request bit self-clears during reset
// - debug reset sets power-on cause flag
// - stop instruction enters stop mode
// - hold CPU 66 or 5000 oscillator cycles
// - hold count includes oscillator startup
// - stop recovery touches only two registers
// - recovery enables, selects internal oscillator
module reset_and_stop_recovery
  import rst_seq_pkg::*;
#(
  parameter int SMR_XTAL_HOLD = `SMR_HOLD_XTAL,
  parameter int POR_DELAY = `POR_DELAY,
  parameter int VBO_DELAY = `VBO_DELAY,
  parameter int WDT_DELAY = `WDT_DELAY,
  parameter int EXT_DELAY = `EXT_DELAY
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // port configuration: indicator during stop-recovery hold
  input wire logic port_indicator_en,
  // internal reset events, one-cycle pulses
  input wire logic por_event,
  input wire logic brownout_event,
  input wire logic watchdog_event,
  // debug unit control
  input wire logic debug_reset_req_set,
  output logic debug_reset_req,
  // cpu stop and wake
  input wire logic stop_exec,
  input wire logic wake_event,
  input wire logic osc_tick,
  input wire logic xtal_enable,
  // oscillator control register writes
  input wire logic osc_write,
  input wire logic osc_write_enable,
  input wire logic osc_write_select,
  output logic osc_internal_enable,
  output logic osc_internal_select,
  // flag clear from software
  input wire logic flags_clear,
  // reset outputs
  output logic sys_reset,
  output logic debug_unit_reset,
  output logic cpu_reset,
  output logic stop_mode,
  // cause flags
  output logic external_reset_flag,
  output logic por_flag,
  output logic brownout_flag,
  output logic watchdog_flag,
  output logic stop_recovery_flag
);
  import rst_seq_pkg::*;

  // ****************************************
  // pin input path
  // ****************************************
  logic pin_level; // synchronised, filtered pin
  logic [1:0] qual_cnt; // agreed-low samples
  logic [2:0] mask_cnt; // masks our own drive echo
  logic [1:0] next_qual_cnt;
  logic [2:0] next_mask_cnt;
  logic ext_low; // pin low and not our own drive
  logic ext_hit; // pulse accepted

  pin_sync u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_raw(rst_pin_in),
    .pin_level(pin_level)
  );

  // own drive comes back through the synchroniser late, so mask it
  assign ext_low = !pin_level && (mask_cnt == 3'h0) && !rst_pin_oe;
  assign ext_hit = (qual_cnt == `EXT_QUAL_CYCLES);

  // qualification and echo mask counters
  always_comb begin
    next_qual_cnt = 2'h0;
    if (ext_low && qual_cnt != `EXT_QUAL_CYCLES) begin
      next_qual_cnt = qual_cnt + 2'h1;
    end else if (ext_low) begin
      next_qual_cnt = qual_cnt;
    end
    next_mask_cnt = mask_cnt;
    if (rst_pin_oe) begin
      next_mask_cnt = `DRIVE_MASK_CYCLES;
    end else if (mask_cnt != 3'h0) begin
      next_mask_cnt = mask_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qual_cnt <= 2'h0;
      mask_cnt <= 3'h0;
    end else begin
      qual_cnt <= next_qual_cnt;
      mask_cnt <= next_mask_cnt;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  seq_state_e state; // current phase
  seq_state_e next_state;
  count_t cnt; // reset delay or stop hold count
  count_t next_cnt;
  logic int_cause; // reset came from an internal source
  logic dbg_cause; // reset came from the debug unit
  logic next_int_cause;
  logic next_dbg_cause;
  logic next_debug_reset_req;
  logic next_osc_en;
  logic next_osc_sel;
  logic next_ext_f;
  logic next_por_f;
  logic next_vbo_f;
  logic next_wdt_f;
  logic next_smr_f;
  logic any_reset; // some source asks for a system reset
  count_t hold_target; // stop hold for the current crystal setting

  assign any_reset = por_event || brownout_event || watchdog_event
                     || ext_hit || debug_reset_req;
  assign hold_target = xtal_enable ? count_t'(SMR_XTAL_HOLD)
                                   : `SMR_HOLD_NOXTAL;

  // next phase, counters and flags; a reset beats every other phase
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_int_cause = int_cause;
    next_dbg_cause = dbg_cause;
    next_debug_reset_req = debug_reset_req;
    next_osc_en = osc_internal_enable;
    next_osc_sel = osc_internal_select;
    next_ext_f = external_reset_flag;
    next_por_f = por_flag;
    next_vbo_f = brownout_flag;
    next_wdt_f = watchdog_flag;
    next_smr_f = stop_recovery_flag;
    // software writes, overridden below by hardware
    if (osc_write) begin
      next_osc_en = osc_write_enable;
      next_osc_sel = osc_write_select;
    end
    if (flags_clear) begin
      next_ext_f = 1'b0;
      next_por_f = 1'b0;
      next_vbo_f = 1'b0;
      next_wdt_f = 1'b0;
      next_smr_f = 1'b0;
    end
    // the bit clears during the reset that it caused
    if (state == ST_RESET && dbg_cause) begin
      next_debug_reset_req = 1'b0;
    end
    if (debug_reset_req_set) begin
      next_debug_reset_req = 1'b1;
    end
    case (state)
      ST_RESET: begin
        if (por_event || brownout_event || watchdog_event) begin
          // fresh internal event restarts the delay
          next_cnt = count_t'(POR_DELAY);
          next_int_cause = 1'b1;
        end else if (cnt != 13'h0000) begin
          next_cnt = cnt - 13'h0001;
        end else if (!ext_low) begin
          next_state = ST_RUN;
          next_int_cause = 1'b0;
          next_dbg_cause = 1'b0;
        end
      end
      ST_RUN, ST_STOP, ST_WAKE: begin
        if (any_reset) begin
          next_state = ST_RESET;
          next_int_cause = !ext_hit;
          next_dbg_cause = 1'b0;
          next_ext_f = 1'b0;
          next_por_f = 1'b0;
          next_vbo_f = 1'b0;
          next_wdt_f = 1'b0;
          next_smr_f = 1'b0;
          next_osc_en = 1'b1;
          next_osc_sel = 1'b1;
          if (por_event) begin
            next_cnt = count_t'(POR_DELAY);
            next_por_f = 1'b1;
          end else if (brownout_event) begin
            next_cnt = count_t'(VBO_DELAY);
            next_vbo_f = 1'b1;
          end else if (watchdog_event) begin
            next_cnt = count_t'(WDT_DELAY);
            next_wdt_f = 1'b1;
          end else if (ext_hit) begin
            next_cnt = count_t'(EXT_DELAY);
            next_ext_f = 1'b1;
          end else begin
            // debug request runs as a power-on reset
            next_cnt = count_t'(POR_DELAY);
            next_por_f = 1'b1;
            next_dbg_cause = 1'b1;
            // pin indicates this reset too, unlike an external one
          end
        end else if (state == ST_RUN && stop_exec) begin
          next_state = ST_STOP;
        end else if (state == ST_STOP && wake_event) begin
          // count starts at wake, so oscillator start-up is inside it
          next_state = ST_WAKE;
          next_cnt = 13'h0000;
          // only oscillator and watchdog-register bits move here
          next_osc_en = 1'b1;
          next_osc_sel = 1'b1;
          next_smr_f = 1'b1;
        end else if (state == ST_WAKE) begin
          next_osc_en = 1'b1;
          next_osc_sel = 1'b1;
          if (osc_tick) begin
            next_cnt = cnt + 13'h0001;
          end
          if (cnt >= hold_target) begin
            next_state = ST_RUN;
          end
        end
      end
      default: begin
        next_state = ST_RESET;
        next_cnt = count_t'(POR_DELAY);
      end
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic next_sys_reset;
  logic next_dbg_unit_rst;
  logic next_cpu_reset;
  logic next_stop_mode;
  logic next_pin_oe;

  // outputs follow the next phase so they line up with the state flop
  always_comb begin
    next_sys_reset = (next_state == ST_RESET);
    next_dbg_unit_rst = next_sys_reset && !next_dbg_cause;
    next_cpu_reset = next_sys_reset || (next_state == ST_WAKE);
    next_stop_mode = (next_state == ST_STOP);
    // external cause is never echoed, or the pin would latch itself low
    next_pin_oe = (next_sys_reset && next_int_cause)
                  || (next_state == ST_WAKE && port_indicator_en);
  end

  // power-up comes out as a power-on reset in progress
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RESET;
      cnt <= count_t'(POR_DELAY);
      int_cause <= 1'b1;
      dbg_cause <= 1'b0;
      debug_reset_req <= 1'b0;
      osc_internal_enable <= 1'b1;
      osc_internal_select <= 1'b1;
      external_reset_flag <= 1'b0;
      por_flag <= 1'b1;
      brownout_flag <= 1'b0;
      watchdog_flag <= 1'b0;
      stop_recovery_flag <= 1'b0;
      sys_reset <= 1'b1;
      debug_unit_reset <= 1'b1;
      cpu_reset <= 1'b1;
      stop_mode <= 1'b0;
      rst_pin_oe <= 1'b1;
      rst_pin_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      int_cause <= next_int_cause;
      dbg_cause <= next_dbg_cause;
      debug_reset_req <= next_debug_reset_req;
      osc_internal_enable <= next_osc_en;
      osc_internal_select <= next_osc_sel;
      external_reset_flag <= next_ext_f;
      por_flag <= next_por_f;
      brownout_flag <= next_vbo_f;
      watchdog_flag <= next_wdt_f;
      stop_recovery_flag <= next_smr_f;
      sys_reset <= next_sys_reset;
      debug_unit_reset <= next_dbg_unit_rst;
      cpu_reset <= next_cpu_reset;
      stop_mode <= next_stop_mode;
      rst_pin_oe <= next_pin_oe;
      rst_pin_out <= 1'b0; // open drain only ever pulls low
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ext_accept: assert property (
    (state == ST_RUN && ext_hit && !debug_reset_req && !por_event
     && !brownout_event && !watchdog_event) |=> external_reset_flag
     && sys_reset)
    else $error("accepted external pulse did not reset");
  a_hold_low: assert property (
    (sys_reset && ext_low) |=> sys_reset)
    else $error("left reset while pin held low");
  a_release_edge: assert property (
    (state == ST_RESET && cnt == 13'h0000 && !ext_low && !por_event
     && !brownout_event && !watchdog_event) |=> !sys_reset)
    else $error("reset not released after pin release");
  a_int_drive: assert property (
    (state == ST_RUN && watchdog_event) |=> rst_pin_oe [*4])
    else $error("pin not driven after internal event");
  a_int_hold: assert property (
    (sys_reset && int_cause && cnt != 13'h0000) |=> rst_pin_oe)
    else $error("pin released before internal delay ended");
  a_dbg_clear: assert property (
    (sys_reset && dbg_cause) |=> !debug_reset_req
     || $past(debug_reset_req_set))
    else $error("debug request bit did not self-clear");
  a_dbg_spare: assert property (
    (state == ST_RUN && debug_reset_req && !ext_hit && !por_event
     && !brownout_event && !watchdog_event)
    |=> sys_reset && !debug_unit_reset && por_flag)
    else $error("debug reset touched the debug unit");
  a_stop_enter: assert property (
    (state == ST_RUN && stop_exec && !any_reset) |=> stop_mode)
    else $error("stop not entered");
  a_wake_osc: assert property (
    (state == ST_STOP && wake_event && !any_reset)
    |=> cpu_reset && osc_internal_enable && osc_internal_select)
    else $error("wake did not force internal oscillator");
  a_short_hold: assert property (
    (state == ST_WAKE && !xtal_enable && cnt < `SMR_HOLD_NOXTAL
     && !any_reset) |=> cpu_reset)
    else $error("cpu released before hold count");

  c_ext_reset: cover property (ext_hit ##1 sys_reset);
  c_dbg_reset: cover property (sys_reset && dbg_cause);
  c_wake_done: cover property (state == ST_WAKE ##1 state == ST_RUN);
  c_stop: cover property (stop_mode ##1 state == ST_WAKE);
endmodule // reset_and_stop_recovery
`default_nettype wire

// file: shared/rst_seq_params.svh
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH
// ****************************************
// reset sequencer constants
// ****************************************
// agreed-low samples that accept an external pulse (4 clk pin pulse)
`define EXT_QUAL_CYCLES 2'd3
// stop-recovery hold, internal oscillator cycles, crystal off
`define SMR_HOLD_NOXTAL 13'd66
// stop-recovery hold, internal oscillator cycles, crystal on
`define SMR_HOLD_XTAL 5000
// per-source reset delays in clk cycles (defaults)
`define POR_DELAY 16
`define VBO_DELAY 16
`define WDT_DELAY 16
`define EXT_DELAY 16
// clk cycles the input stays masked after the pin is released
`define DRIVE_MASK_CYCLES 3'd4
// pin idle level after reset
`define PIN_IDLE 1'b1
`endif

// file: shared/rst_seq_pkg.sv
// ****************************************
// reset sequencer types
// ****************************************
package rst_seq_pkg;
  // sequencer states, binary codes
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RESET = 2'b01,
    ST_STOP = 2'b10,
    ST_WAKE = 2'b11
  } seq_state_e;
  // hold and delay counter
  typedef logic [12:0] count_t;
endpackage

// file: src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_params.svh"
// ****************************************
// three-flop pin synchroniser with agreement filter
// ****************************************
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // raw pin
  input wire logic pin_raw,
  // filtered level
  output logic pin_level
);
  logic ff1; // first stage, read only by ff2
  logic ff2; // second stage
  logic ff3; // third stage
  logic next_level; // level once ff2 and ff3 agree

  // level only moves when the last two stages agree
  always_comb begin
    next_level = pin_level;
    if (ff2 == ff3) begin
      next_level = ff3;
    end
  end

  // flops start at the idle level so no reset is seen at start-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ff1 <= `PIN_IDLE;
      ff2 <= `PIN_IDLE;
      ff3 <= `PIN_IDLE;
      pin_level <= `PIN_IDLE;
    end else begin
      ff1 <= pin_raw;
      ff2 <= ff1;
      ff3 <= ff2;
      pin_level <= next_level;
    end
  end
endmodule // pin_sync
`default_nettype wire

// file: verification/reset_line_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// far-side parts sharing the open-drain reset wire
// ****************************************
module reset_line_peer (
  // clock
  input wire logic clk,
  // device side of the pin
  input wire logic dev_oe,
  input wire logic dev_out,
  // bench command: pull low for pull_len clocks
  input wire logic pull_start,
  input wire logic [7:0] pull_len,
  // resolved wire level
  output logic pin
);
  logic [7:0] cnt; // clocks of pull still to go
  logic ext_pull; // peer holds the wire low

  // pulse length counter, whole clocks only
  always @(posedge clk) begin
    if (pull_start) begin
      cnt <= pull_len;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  initial cnt = 8'h00;
  assign ext_pull = (cnt != 8'h00);
  // pull-up wins only when nobody drives low
  assign pin = (dev_oe ? dev_out : 1'b1) & ~ext_pull;
endmodule // reset_line_peer
`default_nettype wire

// file: verification/reset_and_stop_recovery_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_and_stop_recovery_tb;
  import rst_seq_pkg::*;
  // ****************************************
  // settings and signals
  // ****************************************
  localparam int PD = 4; // short delays keep the run brief
  localparam int VD = 5; // distinct per source to catch mix-ups
  localparam int WD = 6;
  localparam int ED = 3;
  localparam int XH = 20;
  logic clk, arst_n, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic port_indicator_en, por_event, brownout_event, watchdog_event;
  logic debug_reset_req_set, debug_reset_req, stop_exec, wake_event;
  logic osc_tick, xtal_enable, osc_write, osc_write_enable;
  logic osc_write_select, osc_internal_enable, osc_internal_select;
  logic flags_clear, sys_reset, debug_unit_reset, cpu_reset, stop_mode;
  logic external_reset_flag, por_flag, brownout_flag, watchdog_flag;
  logic stop_recovery_flag, pull_start;
  logic [7:0] pull_len;
  wire logic [4:0] flags = {external_reset_flag, por_flag, brownout_flag,
    watchdog_flag, stop_recovery_flag};
  int miscompares, n_checks, n;
  // ordinary cases: event, expected flags, expected hold length
  logic [2:0] ev_row [3] = '{3'b100, 3'b010, 3'b001};
  logic [4:0] fl_row [3] = '{5'b01000, 5'b00100, 5'b00010};
  int len_row [3] = '{PD + 1, VD + 1, WD + 1};

  reset_and_stop_recovery #(.SMR_XTAL_HOLD(XH), .POR_DELAY(PD),
    .VBO_DELAY(VD), .WDT_DELAY(WD), .EXT_DELAY(ED))
    reset_and_stop_recovery_inst (.clk(clk), .arst_n(arst_n),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .port_indicator_en(port_indicator_en),
    .por_event(por_event), .brownout_event(brownout_event),
    .watchdog_event(watchdog_event),
    .debug_reset_req_set(debug_reset_req_set),
    .debug_reset_req(debug_reset_req), .stop_exec(stop_exec),
    .wake_event(wake_event), .osc_tick(osc_tick),
    .xtal_enable(xtal_enable), .osc_write(osc_write),
    .osc_write_enable(osc_write_enable),
    .osc_write_select(osc_write_select),
    .osc_internal_enable(osc_internal_enable),
    .osc_internal_select(osc_internal_select), .flags_clear(flags_clear),
    .sys_reset(sys_reset), .debug_unit_reset(debug_unit_reset),
    .cpu_reset(cpu_reset), .stop_mode(stop_mode),
    .external_reset_flag(external_reset_flag), .por_flag(por_flag),
    .brownout_flag(brownout_flag), .watchdog_flag(watchdog_flag),
    .stop_recovery_flag(stop_recovery_flag));

  reset_line_peer reset_line_peer_inst (.clk(clk), .dev_oe(rst_pin_oe),
    .dev_out(rst_pin_out), .pull_start(pull_start), .pull_len(pull_len),
    .pin(rst_pin_in));

  // ****************************************
  // helpers
  // ****************************************
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // one or more edges, then the fixed drive delay
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // compare, count, report
  task automatic chk(input logic [15:0] seen, exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // bounded wait on sys_reset; a spent bound ends the run
  task automatic wait_sys(input logic lvl, input int lim);
    int i;
    i = 0;
    while (sys_reset !== lvl && i < lim) begin
      step();
      i++;
    end
    chk(sys_reset, lvl, "sys_reset wait ran out");
    if (sys_reset !== lvl) wrap_up();
  endtask

  // clocks that sys_reset stays high
  task automatic hold_len(output int len);
    len = 0;
    while (sys_reset === 1'b1 && len < 300) begin
      step();
      len++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {arst_n, port_indicator_en, por_event, brownout_event} = 4'h0;
    {watchdog_event, debug_reset_req_set, stop_exec, wake_event} = 4'h0;
    {osc_tick, xtal_enable, osc_write, osc_write_enable} = 4'h0;
    {osc_write_select, flags_clear, pull_start} = 3'h0;
    pull_len = 8'h00;
    miscompares = 0;
    n_checks = 0;
    // reset: power-on values, pin driven
    step(2);
    chk({sys_reset, cpu_reset, rst_pin_oe, por_flag}, 4'hF, "reset vals");
    chk({osc_internal_enable, osc_internal_select}, 2'h3, "osc reset");
    arst_n = 1'b1;
    wait_sys(1'b0, PD + 10);
    step(8);
    $display("test reset done");
    // internal events from the table
    for (int r = 0; r < 3; r++) begin
      {por_event, brownout_event, watchdog_event} = ev_row[r];
      step();
      {por_event, brownout_event, watchdog_event} = 3'h0;
      wait_sys(1'b1, 3);
      chk(rst_pin_oe, 1'b1, "pin not driven");
      chk(flags, fl_row[r], "cause flags");
      hold_len(n);
      chk(16'(n), 16'(len_row[r]), "hold length");
      step(8); // pin input stays masked a few clocks
      $display("test event row %0d done", r);
    end
    // four-clock pin pulse always resets
    pull_len = 8'h04;
    pull_start = 1'b1;
    step();
    pull_start = 1'b0;
    wait_sys(1'b1, 10);
    chk(flags, 5'b10000, "external flag");
    wait_sys(1'b0, 40);
    step(8);
    // long hold keeps reset, release ends it promptly
    pull_len = 8'h28;
    pull_start = 1'b1;
    step();
    pull_start = 1'b0;
    wait_sys(1'b1, 10);
    n = 0;
    while (rst_pin_in === 1'b0 && n < 60) begin
      chk(sys_reset, 1'b1, "left reset early");
      step();
      n++;
    end
    wait_sys(1'b0, 6);
    step(8);
    $display("test pin reset done");
    // debug request
    debug_reset_req_set = 1'b1;
    step();
    debug_reset_req_set = 1'b0;
    chk(debug_reset_req, 1'b1, "request bit");
    wait_sys(1'b1, 3);
    chk(debug_unit_reset, 1'b0, "debug unit reset");
    chk(rst_pin_oe, 1'b1, "debug reset pin");
    chk(flags, 5'b01000, "power-on flag");
    step(2);
    chk(debug_reset_req, 1'b0, "request kept");
    wait_sys(1'b0, PD + 3);
    flags_clear = 1'b1;
    step();
    flags_clear = 1'b0;
    step();
    chk(flags, 5'b00000, "flags clear");
    $display("test debug reset done");
    // stop and wake, crystal off then on
    for (int x = 0; x < 2; x++) begin
      osc_write = 1'b1;
      step();
      osc_write = 1'b0;
      step();
      chk({osc_internal_enable, osc_internal_select}, 2'h0, "osc wr");
      xtal_enable = x[0];
      port_indicator_en = x[0];
      stop_exec = 1'b1;
      step();
      stop_exec = 1'b0;
      step();
      chk(stop_mode, 1'b1, "stop mode");
      wake_event = 1'b1;
      step();
      wake_event = 1'b0;
      step();
      chk({cpu_reset, stop_mode, sys_reset}, 3'b100, "wake");
      chk({osc_internal_enable, osc_internal_select}, 2'h3, "osc");
      chk(flags, 5'b00001, "recovery flag only");
      chk(rst_pin_oe, x[0], "indicator");
      osc_write = 1'b1; // refused during hold
      step();
      osc_write = 1'b0;
      n = 0;
      while (cpu_reset === 1'b1 && n < 6000) begin
        osc_tick = 1'b1;
        step();
        osc_tick = 1'b0;
        step();
        n++;
      end
      chk(16'(n), x ? 16'(XH) : 16'd66, "hold ticks");
      chk({osc_internal_enable, osc_internal_select}, 2'h3, "osc");
      $display("test stop recovery %0d done", x);
    end
    // mid-run reset returns the power-on state, pin pulled low
    arst_n = 1'b0;
    step();
    chk({sys_reset, debug_unit_reset, cpu_reset, rst_pin_oe, rst_pin_out,
      stop_mode, flags}, 11'h788, "mid-run reset");
    arst_n = 1'b1;
    wait_sys(1'b0, PD + 10);
    chk(rst_pin_oe, 1'b0, "pin released");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // reset_and_stop_recovery_tb
`default_nettype wire
